// file: verilog/button_press_duration_judge.sv
// Standby sequencer that judges long and short button presses.
//
// Functional notes
// - Both lamp outputs light when driven low and the button reads pressed when low.
// - A button press in deep stop moves the device to state_a without waking the core.
// - The button edge goes through the event link into the sequencer start input.
// - The button edge never reaches the core as a wake request; it only starts the sequencer.
// - The activity lamp is on while the sequencer runs and off once it finishes either way.
// - A hold longer than the threshold is a long press and wakes the device to normal.
// - A hold not beyond the threshold is short and returns to deep stop with the core off.
// - After a long-press wake the long-press lamp lights for one second, then deep stop.
// - Lamp, measurement, decision and wake run entirely in the sequencer without the core.
// - The threshold is 125 ms times one more than a repeat count whose default is 24.
`timescale 1ns/100ps
`default_nettype none
module button_press_duration_judge
	import press_judge_pkg::*;
#(
	parameter int unsigned WAIT_COUNT = WAIT_CYCLES,
	parameter int unsigned LAMP_COUNT = LAMP_CYCLES,
	parameter int unsigned REPEAT     = REPEAT_DEFAULT
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Button pin, active low
	input  wire logic i_push_button_n,
	// Lamp pins, active low
	output logic      o_activity_lamp_n,
	output logic      o_long_press_lamp_n,
	// Power state view
	output logic      o_core_running,
	output logic      o_in_state_a,
	output logic      o_wake_pulse
);
	// Width of the shared timer's count.
	localparam int unsigned TW = 24;

	// Refuse counts that the timer or the repeat counter cannot hold.
	initial begin
		if (WAIT_COUNT < 1 || WAIT_COUNT >= (1 << TW)) begin
			$error("button_press_duration_judge: WAIT_COUNT out of range");
		end
		if (LAMP_COUNT < 1 || LAMP_COUNT >= (1 << TW)) begin
			$error("button_press_duration_judge: LAMP_COUNT out of range");
		end
		if (REPEAT < 1 || REPEAT >= (1 << REPEAT_W)) begin
			$error("button_press_duration_judge: REPEAT out of range");
		end
	end

	// Three-stage synchroniser for the button pin.
	logic       sync [3];
	logic       pressed;
	logic       pressed_d;

	for (genvar g = 0; g < 3; g++) begin : g_sync
		logic stage_in;
		if (g == 0) begin : g_pin
			assign stage_in = i_push_button_n;
		end else begin : g_chain
			assign stage_in = sync[g-1];
		end
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				sync[g] <= SYNC_RESET[g];
			end else begin
				sync[g] <= stage_in;
			end
		end
	end

	// Button level after the synchroniser, low on the pin means pressed.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pressed   <= 1'b0;
			pressed_d <= 1'b0;
		end else begin
			if (sync[1] == sync[2]) begin
				pressed <= ~sync[2];
			end
			pressed_d <= pressed;
		end
	end

	// Edge event, routed through the event link to the sequencer only.
	wire button_edge_interrupt = pressed && !pressed_d;
	wire core_irq_mask         = 1'b1;
	wire core_irq_from_button  = button_edge_interrupt && !core_irq_mask;
	power_state_e state;
	power_state_e next_state;

	// One-hot state decode.
	wire in_deep    = (state == DEEP_STOP);
	wire in_state_a = (state == STATE_A);
	wire in_measure = (state == MEASURE);
	wire in_normal  = (state == NORMAL);
	wire in_lit     = (state == LIT);

	// Only deep stop lets the edge through to the sequencer.
	wire event_link_out = button_edge_interrupt && in_deep;

	// Shared interval timer for waits and the lamp time.
	logic          timer_start;
	logic [TW-1:0] timer_count;
	logic          tick;

	interval_timer #(
		.WIDTH (TW)
	) u_timer (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (timer_start),
		.i_count   (timer_count),
		.o_tick    (tick)
	);

	// Measurement state and verdict decode.
	logic [REPEAT_W-1:0] held;
	logic [REPEAT_W-1:0] next_held;
	verdict_s            verdict;
	lamps_s              lamps;
	lamps_s              next_lamps;
	logic                core_running;
	logic                state_a_view;

	localparam lamps_s LAMPS_DARK = '{activity_lamp_n: LAMP_OFF,
	                                  long_press_lamp_n: LAMP_OFF};

	wire at_threshold = (held == REPEAT[REPEAT_W-1:0]);
	wire sample_now   = in_measure && tick;
	wire still_held   = sample_now && pressed;
	wire released     = sample_now && !pressed;
	wire long_hit     = still_held && at_threshold;

	assign verdict = '{wake: long_hit || core_irq_from_button,
	                   long_press: long_hit,
	                   short_press: released};

	// Timer loads: a wait on entry and after every held sample short of
	// the threshold, the lamp time with the long-press verdict.
	wire start_wait = in_state_a || (still_held && !at_threshold);
	wire start_lamp = long_hit;
	assign timer_start = start_wait || start_lamp;
	assign timer_count = start_lamp ? LAMP_COUNT[TW-1:0] : WAIT_COUNT[TW-1:0];

	// Next state, hold count and lamp levels.
	always_comb begin
		next_state  = state;
		next_held   = held;
		next_lamps  = lamps;
		unique case (state)
			DEEP_STOP: begin
				if (event_link_out) begin
					next_state = STATE_A;
				end
			end
			STATE_A: begin
				next_lamps.activity_lamp_n = LAMP_ON;
				next_held                  = '0;
				next_state                 = MEASURE;
			end
			MEASURE: begin
				if (verdict.long_press) begin
					next_lamps.activity_lamp_n   = LAMP_OFF;
					next_lamps.long_press_lamp_n = LAMP_ON;
					next_state                   = NORMAL;
				end else if (verdict.short_press) begin
					next_lamps.activity_lamp_n = LAMP_OFF;
					next_state                 = DEEP_STOP;
				end else if (still_held) begin
					next_held   = held + 1'b1;
				end
			end
			NORMAL: begin
				next_state = LIT;
			end
			LIT: begin
				if (tick) begin
					next_lamps.long_press_lamp_n = LAMP_OFF;
					next_state                   = DEEP_STOP;
				end
			end
			default: begin
				next_state = DEEP_STOP;
			end
		endcase
	end

	// State, count, lamps and the wake pulse.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state        <= DEEP_STOP;
			held         <= '0;
			lamps        <= LAMPS_DARK;
			o_wake_pulse <= 1'b0;
		end else begin
			state        <= next_state;
			held         <= next_held;
			lamps        <= next_lamps;
			o_wake_pulse <= verdict.wake;
		end
	end

	// Status pins come from flip-flops loaded with the next state.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			core_running <= 1'b0;
			state_a_view  <= 1'b0;
		end else begin
			core_running <= (next_state == NORMAL) || (next_state == LIT);
			state_a_view  <= (next_state == STATE_A) || (next_state == MEASURE);
		end
	end

	// Pin drivers.
	assign o_activity_lamp_n   = lamps.activity_lamp_n;
	assign o_long_press_lamp_n = lamps.long_press_lamp_n;
	assign o_core_running      = core_running;
	assign o_in_state_a        = state_a_view;
endmodule // button_press_duration_judge
`default_nettype wire

// file: verilog/press_judge_pkg.sv
// Package with constants and types for the button press duration judge.
package press_judge_pkg;
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned WAIT_MS          = 125;
	localparam int unsigned LAMP_MS          = 1000;
	localparam int unsigned WAIT_CYCLES      = (CLK_HZ / 1000) * WAIT_MS;
	localparam int unsigned LAMP_CYCLES      = (CLK_HZ / 1000) * LAMP_MS;
	localparam int unsigned REPEAT_DEFAULT   = 24;
	localparam int unsigned REPEAT_W         = 8;
	localparam logic        LAMP_ON          = 1'b0;
	localparam logic        LAMP_OFF         = 1'b1;
	localparam logic [2:0]  SYNC_RESET       = 3'h7;

	typedef enum logic [4:0] {
		DEEP_STOP = 5'h01,
		STATE_A   = 5'h02,
		MEASURE   = 5'h04,
		NORMAL    = 5'h08,
		LIT       = 5'h10
	} power_state_e;

	typedef struct packed {
		logic activity_lamp_n;
		logic long_press_lamp_n;
	} lamps_s;

	typedef struct packed {
		logic wake;
		logic long_press;
		logic short_press;
	} verdict_s;
endpackage : press_judge_pkg

// file: verilog/interval_timer.sv
// Interval timer that emits a one-cycle tick after a loadable count.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
	parameter int unsigned WIDTH = 24
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	// Control
	input  wire logic             i_start,
	input  wire logic [WIDTH-1:0] i_count,
	// Status
	output logic                  o_tick
);
	initial begin
		if (WIDTH < 2 || WIDTH > 31) begin
			$error("interval_timer: WIDTH out of range");
		end
	end

	logic [WIDTH-1:0] remain;
	logic             running;
	wire              expire = running && (remain == '0);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			remain  <= '0;
			running <= 1'b0;
			o_tick  <= 1'b0;
		end else begin
			o_tick <= expire;
			if (i_start) begin
				remain  <= i_count - 1'b1;
				running <= 1'b1;
			end else if (expire) begin
				running <= 1'b0;
			end else if (running) begin
				remain <= remain - 1'b1;
			end
		end
	end
endmodule // interval_timer
`default_nettype wire

// file: test/press_judge_props.sv
// Checker of the lamp, wake and state pins of the press judge.
`timescale 1ns/100ps
`default_nettype none
module press_judge_props (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_push_button_n,
	input wire logic o_activity_lamp_n,
	input wire logic o_long_press_lamp_n,
	input wire logic o_core_running,
	input wire logic o_in_state_a,
	input wire logic o_wake_pulse
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	wire deep = !o_in_state_a && !o_core_running;
	a_wake_one_cycle: assert property (o_wake_pulse |=> !o_wake_pulse)
		else $error("wake too long");
	a_wake_lamps: assert property (o_wake_pulse |-> o_core_running &&
		!o_long_press_lamp_n && o_activity_lamp_n) else $error("wake lamps");
	a_core_off_state_a: assert property (o_in_state_a |-> !o_core_running)
		else $error("core in state_a");
	a_deep_lamps_off: assert property (deep |-> o_activity_lamp_n &&
		o_long_press_lamp_n) else $error("lamp in deep stop");
	a_core_by_wake: assert property ($rose(o_core_running) |-> o_wake_pulse)
		else $error("core without wake");
	a_lamp_one_sec: assert property ($fell(o_long_press_lamp_n) |->
		(!o_long_press_lamp_n)[*8] ##[11:16] $rose(o_long_press_lamp_n))
		else $error("long lamp time");
	a_state_a_lamp_on: assert property (o_in_state_a && $past(o_in_state_a)
		|-> !o_activity_lamp_n) else $error("activity lamp off");
	a_press_starts: assert property ($fell(i_push_button_n) && deep
		|-> ##[3:7] o_in_state_a) else $error("press ignored");
endmodule // press_judge_props
`default_nettype wire

// file: test/button_lamp_model.sv
// Model of the push button and the two lamps at the judge's pins.
`timescale 1ns/100ps
`default_nettype none
module button_lamp_model (
	input  wire logic i_press,
	input  wire logic i_activity_lamp_n,
	input  wire logic i_long_press_lamp_n,
	output logic      o_push_button_n,
	output logic      o_activity_lit,
	output logic      o_long_lit
);
	assign o_push_button_n = !i_press;
	assign o_activity_lit  = !i_activity_lamp_n;
	assign o_long_lit      = !i_long_press_lamp_n;
endmodule // button_lamp_model
`default_nettype wire

// file: test/button_press_duration_judge_tb_top.sv
// Testbench of the button press duration judge.
`timescale 1ns/100ps
`default_nettype none
module button_press_duration_judge_tb_top;
	import press_judge_pkg::*;
	logic clk, rst, press, btn_n, act_n, long_n, core, snz, wake, act, lng;
	logic w, a;
	int   fails, checked, lit;
	int   hold [4] = '{20, 42, 62, 120};
	logic exp_w [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	button_press_duration_judge #(.WAIT_COUNT(10), .LAMP_COUNT(20),
		.REPEAT(3)) button_press_duration_judge_i (.i_clk(clk),
		.i_sys_rst(rst), .i_push_button_n(btn_n), .o_activity_lamp_n(act_n),
		.o_long_press_lamp_n(long_n), .o_core_running(core),
		.o_in_state_a(snz), .o_wake_pulse(wake));
	button_lamp_model button_lamp_model_i (.i_press(press),
		.i_activity_lamp_n(act_n), .i_long_press_lamp_n(long_n),
		.o_push_button_n(btn_n), .o_activity_lit(act), .o_long_lit(lng));
	task automatic check(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic run(input int h);
		lit = 0; w = 0; a = 0; press = 1;
		for (int t = 0; t < 400; t++) begin
			@(negedge clk);
			if (t == h) press = 0;
			w = w | wake;
			a = a | act;
			lit += int'(lng);
			if (t > h && snz !== 1'b1 && core !== 1'b1) break;
		end
	endtask
	task report_and_stop;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		#300000;
		fails++;
		report_and_stop;
	end
	initial begin
		rst = 1; press = 0; fails = 0; checked = 0;
		repeat (12) @(negedge clk);
		check(act_n === LAMP_OFF && long_n === LAMP_OFF && core === 1'b0 &&
			snz === 1'b0 && wake === 1'b0, "reset");
		rst = 0;
		for (int r = 0; r < 4; r++) begin
			run(hold[r]);
			check(w === exp_w[r], "wake");
			check(a === 1'b1, "activity lamp");
			check(exp_w[r] ? (lit >= 20 && lit <= 22) : lit == 0, "lamp");
			repeat (3) @(negedge clk);
		end
		// A press while awake must not start the sequencer.
		press = 1;
		repeat (56) @(negedge clk);
		press = 0;
		repeat (2) @(negedge clk);
		press = 1;
		repeat (6) @(negedge clk);
		check(snz === 1'b0 && core === 1'b1, "press while awake");
		press = 0;
		repeat (30) @(negedge clk);
		check(core === 1'b0 && long_n === LAMP_OFF, "back to sleep");
		// Reset in mid-measure puts the lamp out.
		press = 1;
		repeat (15) @(negedge clk);
		press = 0; rst = 1;
		repeat (2) @(negedge clk);
		check(act_n === LAMP_OFF && snz === 1'b0, "mid reset");
		rst = 0;
		repeat (3) @(negedge clk);
		report_and_stop;
	end
endmodule // button_press_duration_judge_tb_top
bind button_press_duration_judge press_judge_props press_judge_props_i (
	.i_clk, .i_sys_rst, .i_push_button_n, .o_activity_lamp_n,
	.o_long_press_lamp_n, .o_core_running, .o_in_state_a, .o_wake_pulse);
`default_nettype wire
